// *** daqio_pkg.sv ***
// Function
// - decode 32 consecutive byte addresses starting at a configurable base
// - registers selected by byte offset added to the base address
// - offset 0 reads result bits 3..0 and channel; offset 1 reads bits 11..4
// - digital input ports read lines 7..0 and 15..8 through a two-stage synchroniser
// - digital output writes latch lines; no readback
// - offsets 17H/18H read oldest buffered result, same layout as direct result
// - any write to buffer interrupt clear port drops pending buffer request, unless a new one is set in that same cycle
// - three 16-bit counters, two form the pacer, one free for the user
// - counter 2 clocked by counter 1 output
// - counter 1 base clock 10 MHz or 1 MHz by board switch
// - counter 0 clock internal 100 kHz or external, chosen by timer control
// - pacer rates from 0.00023 Hz to 10 MHz
// - mux addresses 16 single-ended or 8 differential channels, 4-bit numbers
// - result buffer holds 4K samples in order with channel numbers
// - with software trigger selected, any write to offset 0 starts a conversion when none is busy
// - scan limit write resets mux to start; completed conversions advance and wrap
// - range code write stored for the current scan start channel
// - dac low byte held until high byte write updates both in one step
package daqio_pkg;
   //----------------------------------------
   // offsets
   //----------------------------------------
   localparam logic [4:0] OFS_RESULT_LOW = 5'h00;
   localparam logic [4:0] OFS_RESULT_HIGH = 5'h01;
   localparam logic [4:0] OFS_SCAN = 5'h02;
   localparam logic [4:0] OFS_DIO_LOW = 5'h03;
   localparam logic [4:0] OFS_DAC_LOW = 5'h04;
   localparam logic [4:0] OFS_DAC_HIGH = 5'h05;
   localparam logic [4:0] OFS_BUF_IRQ_CTRL = 5'h06;
   localparam logic [4:0] OFS_STATUS = 5'h08;
   localparam logic [4:0] OFS_CONV_CTRL = 5'h09;
   localparam logic [4:0] OFS_TIMER_CTRL = 5'h0a;
   localparam logic [4:0] OFS_DIO_HIGH = 5'h0b;
   localparam logic [4:0] OFS_CNT0 = 5'h0c;
   localparam logic [4:0] OFS_CNT1 = 5'h0d;
   localparam logic [4:0] OFS_CNT2 = 5'h0e;
   localparam logic [4:0] OFS_CNT_MODE = 5'h0f;
   localparam logic [4:0] OFS_BUF_IRQ_CLR = 5'h14;
   localparam logic [4:0] OFS_BUF_LOW = 5'h17;
   localparam logic [4:0] OFS_BUF_HIGH = 5'h18;
   localparam int BLOCK_BYTES = 32;
   //----------------------------------------
   // fields and timing
   //----------------------------------------
   localparam logic [1:0] TRIG_SOFT = 2'h0;
   localparam logic [1:0] TRIG_EXT = 2'h2;
   localparam logic [1:0] TRIG_PACER = 2'h3;
   localparam int CLK_HZ = 100_000_000;
   localparam int INT_CLK_HZ = 100_000;
   localparam int FAST_BASE_HZ = 10_000_000;
   localparam int SLOW_BASE_HZ = 1_000_000;
   localparam int INT_DIV = CLK_HZ / INT_CLK_HZ;
   localparam int FAST_DIV = CLK_HZ / FAST_BASE_HZ;
   localparam int SLOW_DIV = CLK_HZ / SLOW_BASE_HZ;
   localparam int BUF_DEPTH = 4096;
   localparam logic [15:0] CNT_RESET = 16'hffff;

   typedef struct packed {
      logic [4:0] addr;
      logic rd;
      logic wr;
      logic [7:0] data;
   } daqio_bus_type;

   typedef struct packed {
      logic [11:0] value;
      logic [3:0] chan;
   } daqio_sample_type;
endpackage

// *** daqio_counter.sv ***
// one 16-bit down counter channel of the pacer/timer
module daqio_counter
   import daqio_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // clock
   input wire logic sys_clk,
   input wire logic rstn,
   // control
   input wire logic tick,
   input wire logic load,
   input wire logic [WIDTH-1:0] loadValue,
   // state
   output logic [WIDTH-1:0] count,
   output logic pulse
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic [WIDTH-1:0] reload;
      logic pulse;
   } daqio_cnt_state_type;

   daqio_cnt_state_type state, next_state;

   always_comb begin
      next_state = state;
      next_state.pulse = 1'b0;
      if (load) begin
         next_state.reload = loadValue;
         next_state.count = loadValue;
      end else if (tick) begin
         // a reload of zero wraps through the full range before its pulse
         if (state.count == WIDTH'(1)) begin
            next_state.count = state.reload;
            next_state.pulse = 1'b1;
         end else begin
            next_state.count = state.count - WIDTH'(1);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state.count <= WIDTH'(CNT_RESET);
         state.reload <= WIDTH'(CNT_RESET);
         state.pulse <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   assign count = state.count;
   assign pulse = state.pulse;
endmodule

// *** daqio_register_decoder.sv ***
module daqio_register_decoder
   import daqio_pkg::*;
#(
   parameter int DEPTH = BUF_DEPTH,
   parameter logic [9:0] BASE_ADDR = 10'h300
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // host i/o bus
   input wire logic [9:0] ioAddr,
   input wire logic ioRd,
   input wire logic ioWr,
   input wire logic [7:0] ioWrData,
   output logic [7:0] ioRdData,
   output logic ioRdValid,
   // converter side
   input wire logic convDone,
   input wire logic [11:0] convValue,
   input wire logic extTrigger,
   input wire logic extCounterClk,
   input wire logic baseClkSlow,
   input wire logic inputConfigFlag,
   output logic convStart,
   output logic [3:0] muxChannel,
   output logic [3:0] rangeCodeBits,
   // digital input and output lines, analog and timer outputs, interrupts
   input wire logic [15:0] digitalInputLines,
   output logic [15:0] digitalOutputLines,
   output logic [11:0] dacValueBits,
   output logic pacerOut,
   output logic counter0Out,
   output logic bufferIrq,
   output logic convIrq
);
   localparam int AW = $clog2(DEPTH);
   localparam int IDW = $clog2(INT_DIV);

   //----------------------------------------
   // input synchronisers
   //----------------------------------------
   logic [15:0] dinMeta, dinSync;
   logic [3:0] pinMeta, pinSync;
   always_ff @(posedge sys_clk) begin
      dinMeta <= digitalInputLines;
      dinSync <= dinMeta;
      pinMeta <= {extTrigger, extCounterClk, baseClkSlow, inputConfigFlag};
      pinSync <= pinMeta;
   end

   //----------------------------------------
   // address decode
   //----------------------------------------
   function automatic logic hit(input logic [9:0] a);
      hit = (a >= BASE_ADDR) && (a < BASE_ADDR + 10'(BLOCK_BYTES));
   endfunction

   daqio_bus_type bus;
   logic [9:0] rel;
   always_comb begin
      rel = ioAddr - BASE_ADDR;
      bus.addr = rel[4:0];
      bus.rd = ioRd && hit(ioAddr);
      bus.wr = ioWr && hit(ioAddr);
      bus.data = ioWrData;
   end

   function automatic logic wrAt(input daqio_bus_type b, input logic [4:0] o);
      wrAt = b.wr && (b.addr == o);
   endfunction

   //----------------------------------------
   // state
   //----------------------------------------
   typedef struct packed {
      logic [7:0] rdData;
      logic rdValid;
      daqio_sample_type result;
      logic [3:0] startChan;
      logic [3:0] stopChan;
      logic [3:0] curChan;
      logic [15:0] dout;
      logic [3:0] dacLowHold;
      logic [11:0] dac;
      logic bufIrqEnable;
      logic bufIrqPend;
      logic irqPend;
      logic [7:0] convCtrl;
      logic [1:0] timerCtrl;
      logic convBusy;
      logic convStart;
      logic [AW:0] wrPtr;
      logic [AW:0] rdPtr;
      daqio_sample_type bufHold;
      logic bufHighPending;
      logic [3:0] extPrev;
      logic [7:0] cntLatchLow;
      logic [2:0] cntByteSel;
      logic pacerOut;
      logic cnt0Out;
      logic [3:0] rangeOut;
      logic convIrq;
   } daqio_state_type;

   daqio_state_type state, next_state;

   //----------------------------------------
   // range ram and result buffer
   //----------------------------------------
   logic [3:0] rangeRam [16];
   daqio_sample_type bufMem [DEPTH];
   daqio_sample_type bufHead;
   logic [AW:0] fill;
   logic bufFull, bufEmpty;
   assign fill = state.wrPtr - state.rdPtr;
   assign bufFull = fill == (AW+1)'(DEPTH);
   assign bufEmpty = fill == '0;
   assign bufHead = bufMem[state.rdPtr[AW-1:0]];

   always_ff @(posedge sys_clk) begin
      if (wrAt(bus, OFS_RESULT_HIGH)) begin
         rangeRam[state.startChan] <= bus.data[3:0];
      end
      if (convDone && !bufFull) begin
         bufMem[state.wrPtr[AW-1:0]] <= '{value: convValue, chan: state.curChan};
      end
   end

   //----------------------------------------
   // counters and clock enables
   //----------------------------------------
   logic [IDW-1:0] divInt;
   logic [6:0] divBase;
   logic intTick, baseTick;
   logic [6:0] baseDivTop;
   assign baseDivTop = pinSync[1] ? 7'(SLOW_DIV - 1) : 7'(FAST_DIV - 1);
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         divInt <= '0;
         divBase <= '0;
      end else begin
         divInt <= (divInt == IDW'(INT_DIV - 1)) ? '0 : divInt + IDW'(1);
         divBase <= (divBase >= baseDivTop) ? '0 : divBase + 7'(1);
      end
   end
   assign intTick = divInt == '0;
   assign baseTick = divBase == '0;

   logic extClkRise;
   assign extClkRise = pinSync[2] && !state.extPrev[2];

   logic [2:0] cntTick, cntLoad, cntPulse;
   logic [15:0] cntCount [3];
   logic [15:0] cntValue;
   logic [1:0] cntSel;
   assign cntTick[0] = state.timerCtrl[0] ? extClkRise : intTick;
   assign cntTick[1] = baseTick;
   assign cntTick[2] = cntPulse[1];
   assign cntSel = 2'(bus.addr - OFS_CNT0);
   assign cntValue = {bus.data, state.cntLatchLow};

   for (genvar i = 0; i < 3; i++) begin : g_cnt
      assign cntLoad[i] = wrAt(bus, OFS_CNT0 + 5'(i)) && state.cntByteSel[i];
      daqio_counter #(.WIDTH(16)) u_cnt (
         .sys_clk(sys_clk),
         .rstn(rstn),
         .tick(cntTick[i]),
         .load(cntLoad[i]),
         .loadValue(cntValue),
         .count(cntCount[i]),
         .pulse(cntPulse[i])
      );
   end

   //----------------------------------------
   // next state
   //----------------------------------------
   logic trigger;
   logic bufHalf;
   always_comb begin
      next_state = state;
      next_state.rdValid = bus.rd;
      next_state.convStart = 1'b0;
      next_state.extPrev = pinSync;
      trigger = 1'b0;
      bufHalf = convDone && state.bufIrqEnable && fill == (AW+1)'(DEPTH / 2 - 1);
      // pacer edge from counter 2, ext rising edge, or software write
      case (state.convCtrl[1:0])
         TRIG_SOFT: trigger = wrAt(bus, OFS_RESULT_LOW);
         TRIG_EXT: trigger = pinSync[3] && !state.extPrev[3];
         TRIG_PACER: trigger = cntPulse[2];
         default: trigger = 1'b0;
      endcase
      if (cntPulse[2]) begin
         next_state.pacerOut = !state.pacerOut;
      end
      if (cntPulse[0]) begin
         next_state.cnt0Out = !state.cnt0Out;
      end
      if (trigger && !state.convBusy) begin
         next_state.convStart = 1'b1;
         next_state.convBusy = 1'b1;
      end
      if (convDone) begin
         next_state.convBusy = 1'b0;
         next_state.result = '{value: convValue, chan: state.curChan};
         next_state.irqPend = 1'b1;
         if (!bufFull) begin
            next_state.wrPtr = state.wrPtr + (AW+1)'(1);
         end
         // advance scan after the sample is tagged
         if (state.curChan == state.stopChan) begin
            next_state.curChan = state.startChan;
         end else begin
            next_state.curChan = state.curChan + 4'(1);
         end
         if (bufHalf) begin
            next_state.bufIrqPend = 1'b1;
         end
      end
      if (bus.wr) begin
         case (bus.addr)
            OFS_SCAN: begin
               next_state.stopChan = bus.data[7:4];
               next_state.startChan = bus.data[3:0];
               next_state.curChan = bus.data[3:0];
            end
            OFS_DIO_LOW: next_state.dout[7:0] = bus.data;
            OFS_DIO_HIGH: next_state.dout[15:8] = bus.data;
            OFS_DAC_LOW: next_state.dacLowHold = bus.data[7:4];
            OFS_DAC_HIGH: next_state.dac = {bus.data, state.dacLowHold};
            OFS_BUF_IRQ_CTRL: next_state.bufIrqEnable = bus.data[0];
            OFS_STATUS: next_state.irqPend = convDone; // set wins
            OFS_CONV_CTRL: next_state.convCtrl = bus.data;
            OFS_TIMER_CTRL: next_state.timerCtrl = bus.data[1:0];
            OFS_CNT0, OFS_CNT1, OFS_CNT2: begin
               // low byte then high byte
               next_state.cntLatchLow = bus.data;
               next_state.cntByteSel[cntSel] = !state.cntByteSel[cntSel];
            end
            OFS_CNT_MODE: next_state.cntByteSel = '0;
            OFS_BUF_IRQ_CLR: next_state.bufIrqPend = bufHalf; // set wins
            default: ;
         endcase
      end
      // read data and pop side effect
      next_state.rdData = 8'h00;
      if (bus.rd) begin
         case (bus.addr)
            OFS_RESULT_LOW: next_state.rdData = {state.result.value[3:0], state.result.chan};
            OFS_RESULT_HIGH: next_state.rdData = state.result.value[11:4];
            OFS_SCAN: next_state.rdData = {4'h0, state.curChan};
            OFS_DIO_LOW: next_state.rdData = dinSync[7:0];
            OFS_DIO_HIGH: next_state.rdData = dinSync[15:8];
            OFS_STATUS: next_state.rdData = {state.convBusy, 1'b0, pinSync[0], state.irqPend, state.curChan};
            OFS_CONV_CTRL: next_state.rdData = state.convCtrl;
            OFS_CNT0, OFS_CNT1, OFS_CNT2: next_state.rdData = cntCount[cntSel][7:0];
            OFS_BUF_LOW: begin
               // pop on the low read; high read returns the held entry
               next_state.bufHold = bufEmpty ? '0 : bufHead;
               next_state.rdData = bufEmpty ? 8'h00 : {bufHead.value[3:0], bufHead.chan};
               if (!bufEmpty) begin
                  next_state.rdPtr = state.rdPtr + (AW+1)'(1);
               end
            end
            OFS_BUF_HIGH: next_state.rdData = state.bufHold.value[11:4];
            default: next_state.rdData = 8'h00;
         endcase
      end
      // range ram is written on this same edge, so pass the new code through
      next_state.rangeOut = rangeRam[next_state.curChan];
      if (wrAt(bus, OFS_RESULT_HIGH) && next_state.curChan == state.startChan) begin
         next_state.rangeOut = bus.data[3:0];
      end
      next_state.convIrq = next_state.irqPend && next_state.convCtrl[7];
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   //----------------------------------------
   // outputs
   //----------------------------------------
   assign ioRdData = state.rdData;
   assign ioRdValid = state.rdValid;
   assign convStart = state.convStart;
   assign muxChannel = state.curChan;
   assign rangeCodeBits = state.rangeOut;
   assign digitalOutputLines = state.dout;
   assign dacValueBits = state.dac;
   assign pacerOut = state.pacerOut;
   assign counter0Out = state.cnt0Out;
   assign bufferIrq = state.bufIrqPend;
   assign convIrq = state.convIrq;

   //----------------------------------------
   // checks
   //----------------------------------------
   a_scan_reset: assert property (@(posedge sys_clk) disable iff (!rstn)
      wrAt(bus, OFS_SCAN) |=> muxChannel == $past(bus.data[3:0]))
      else $error("scan write did not reset channel");
   a_scan_wrap: assert property (@(posedge sys_clk) disable iff (!rstn)
      convDone && !bus.wr && state.curChan == state.stopChan |=> muxChannel == $past(state.startChan))
      else $error("scan did not wrap");
   a_dac_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
      !wrAt(bus, OFS_DAC_HIGH) |=> $stable(dacValueBits))
      else $error("dac changed without high write");
   a_dac_update: assert property (@(posedge sys_clk) disable iff (!rstn)
      wrAt(bus, OFS_DAC_HIGH) |=> dacValueBits[11:4] == $past(bus.data))
      else $error("dac high byte lost");
   a_dout_latch: assert property (@(posedge sys_clk) disable iff (!rstn)
      wrAt(bus, OFS_DIO_LOW) |=> digitalOutputLines[7:0] == $past(bus.data))
      else $error("digital output not latched");
   a_soft_trig: assert property (@(posedge sys_clk) disable iff (!rstn)
      wrAt(bus, OFS_RESULT_LOW) && state.convCtrl[1:0] == TRIG_SOFT && !state.convBusy |=> convStart)
      else $error("software trigger lost");
   a_bufirq_clr: assert property (@(posedge sys_clk) disable iff (!rstn)
      wrAt(bus, OFS_BUF_IRQ_CLR) && !bufHalf |=> !bufferIrq)
      else $error("buffer irq not cleared");
   a_din_read: assert property (@(posedge sys_clk) disable iff (!rstn)
      bus.rd && bus.addr == OFS_DIO_HIGH |=> ioRdData == $past(dinSync[15:8]))
      else $error("digital input read wrong");
   a_unused_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
      bus.rd && bus.addr == 5'h07 |=> ioRdData == 8'h00 && $stable(state.rdPtr))
      else $error("unused read had effect");
   a_miss_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
      ioRd && !hit(ioAddr) |=> !ioRdValid)
      else $error("out of block access answered");
   c_soft_conv: cover property (@(posedge sys_clk) convStart ##[1:20] convDone);
   c_buf_pop: cover property (@(posedge sys_clk) bus.rd && bus.addr == OFS_BUF_LOW && !bufEmpty);
   c_pacer: cover property (@(posedge sys_clk) cntPulse[2]);
   c_wrap: cover property (@(posedge sys_clk) convDone && state.curChan == state.stopChan);
endmodule

// *** daqio_conv_model.sv ***
//----------------------------------------
// converter stand-in: answers each start with one done pulse
//----------------------------------------
module daqio_conv_model
   import daqio_pkg::*;
(
   // clock
   input wire logic sys_clk,
   input wire logic rstn,
   // handshake
   input wire logic convStart,
   input wire logic [11:0] nextValue,
   input wire logic [3:0] latency,
   output logic convDone,
   output logic [11:0] convValue
);
   timeunit 1ns;
   timeprecision 1ns;
   int waitCnt = -1;
   initial begin
      convDone = 1'b0;
      convValue = 12'h0a5;
   end
   always @(posedge sys_clk) begin
      convDone <= 1'b0;
      // result lines wander outside the done cycle so a stale sample never matches
      convValue <= ~convValue;
      if (!rstn) begin
         waitCnt <= -1;
      end else if (convStart && waitCnt < 0) begin
         waitCnt <= int'(latency);
      end else if (waitCnt == 0) begin
         convDone <= 1'b1;
         convValue <= nextValue;
         waitCnt <= -1;
      end else if (waitCnt > 0) begin
         waitCnt <= waitCnt - 1;
      end
   end
endmodule

// *** daqio_register_decoder_test.sv ***
module daqio_register_decoder_test
   import daqio_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   //----------------------------------------
   // signals
   //----------------------------------------
   localparam logic [9:0] BASE = 10'h300;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [9:0] ioAddr = 10'h000;
   logic ioRd = 1'b0;
   logic ioWr = 1'b0;
   logic [7:0] ioWrData = 8'h00;
   logic [7:0] ioRdData;
   logic ioRdValid, convDone, convStart, pacerOut, counter0Out, bufferIrq, convIrq;
   logic [11:0] convValue, dacValueBits;
   logic [11:0] nextValue = 12'h000;
   logic [3:0] latency = 4'h2;
   logic [3:0] muxChannel, rangeCodeBits;
   logic [15:0] digitalInputLines = 16'h0000;
   logic [15:0] digitalOutputLines;
   logic extTrigger = 1'b0;
   logic extCounterClk = 1'b0;
   logic baseClkSlow = 1'b0;
   logic [15:0] expSample[$];
   logic [15:0] expDout = 16'h0000;
   logic [11:0] expDac = 12'h000;
   logic [3:0] expMux = 4'h0;
   int numErrors = 0;
   int testsRun = 0;
   int seed = 43;
   int cycles = 0;

   daqio_register_decoder #(.DEPTH(16), .BASE_ADDR(BASE)) dut_u (
      .sys_clk(sys_clk), .rstn(rstn), .ioAddr(ioAddr), .ioRd(ioRd), .ioWr(ioWr),
      .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdValid(ioRdValid),
      .convDone(convDone), .convValue(convValue), .extTrigger(extTrigger), .extCounterClk(extCounterClk),
      .baseClkSlow(baseClkSlow), .inputConfigFlag(1'b0), .convStart(convStart),
      .muxChannel(muxChannel), .rangeCodeBits(rangeCodeBits),
      .digitalInputLines(digitalInputLines), .digitalOutputLines(digitalOutputLines),
      .dacValueBits(dacValueBits), .pacerOut(pacerOut), .counter0Out(counter0Out),
      .bufferIrq(bufferIrq), .convIrq(convIrq));

   daqio_conv_model conv_u (
      .sys_clk(sys_clk), .rstn(rstn), .convStart(convStart), .nextValue(nextValue),
      .latency(latency), .convDone(convDone), .convValue(convValue));

   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   //----------------------------------------
   // helpers
   //----------------------------------------
   task automatic stopTest();
      $display("errors %0d checks %0d", numErrors, testsRun);
      if (numErrors == 0 && testsRun > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         $display("[ERR] timeout expected done seen hang");
         numErrors = numErrors + 1;
         stopTest();
      end
   end

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      testsRun = testsRun + 1;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         numErrors = numErrors + 1;
      end
   endtask

   // cycles between two toggles of the pacer output
   task automatic pacerPeriod(input int exp);
      int n;
      logic last;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         last = pacerOut;
         while (pacerOut === last && n < 1000) begin
            @(posedge sys_clk);
            #1;
            n = n + 1;
         end
      end
      check("pacerPeriod", 16'(exp), 16'(n));
   endtask

   function automatic logic [9:0] at(input logic [4:0] ofs);
      return BASE + {5'h00, ofs};
   endfunction

   // returns just after the taking edge, where the design's answer is settled
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      ioAddr <= a;
      ioWrData <= d;
      ioWr <= 1'b1;
      @(posedge sys_clk);
      ioWr <= 1'b0;
      #1;
   endtask

   task automatic rdChk(input logic [9:0] a, input logic [7:0] mask, input logic [7:0] exp,
                        input logic valid);
      @(posedge sys_clk);
      ioAddr <= a;
      ioRd <= 1'b1;
      @(posedge sys_clk);
      ioRd <= 1'b0;
      #1;
      check("rdValid", 16'(valid), 16'(ioRdValid));
      if (valid) begin
         check("rdData", 16'(exp & mask), 16'(ioRdData & mask));
      end
   endtask

   task automatic convert(input logic [3:0] first, input logic [3:0] last);
      int n;
      nextValue = 12'($random(seed));
      latency = 4'(($random(seed) & 7) + 1);
      wr(at(OFS_RESULT_LOW), 8'($random(seed)));
      check("convStart", 16'h0001, 16'(convStart));
      expSample.push_back({nextValue, expMux});
      expMux = (expMux == last) ? first : expMux + 4'h1;
      n = 0;
      while (convDone !== 1'b1 && n < 40) begin
         @(posedge sys_clk);
         #1;
         n = n + 1;
      end
      check("convDone", 16'h0001, 16'(convDone));
      // the channel advances on the edge that takes the done pulse
      rdChk(at(OFS_SCAN), 8'h0f, 8'(expMux), 1'b1);
      check("muxChannel", 16'(expMux), 16'(muxChannel));
      rdChk(at(OFS_RESULT_LOW), 8'hff, {nextValue[3:0], expSample[$][3:0]}, 1'b1);
      rdChk(at(OFS_RESULT_HIGH), 8'hff, nextValue[11:4], 1'b1);
   endtask
   //----------------------------------------
   // main sequence
   //----------------------------------------
   initial begin
      logic [7:0] lo;
      logic [7:0] hi;
      logic [15:0] s;
      logic c0;
      int n;
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      #1;
      check("dout", 16'h0000, digitalOutputLines);
      check("dac", 16'h0000, 16'(dacValueBits));
      // digital lines, random both ways
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk);
         digitalInputLines <= 16'($random(seed));
         repeat (3) @(posedge sys_clk);
         rdChk(at(OFS_DIO_LOW), 8'hff, digitalInputLines[7:0], 1'b1);
         rdChk(at(OFS_DIO_HIGH), 8'hff, digitalInputLines[15:8], 1'b1);
         expDout = 16'($random(seed));
         wr(at(OFS_DIO_LOW), expDout[7:0]);
         wr(at(OFS_DIO_HIGH), expDout[15:8]);
         check("dout", expDout, digitalOutputLines);
         rdChk(at(OFS_DIO_LOW), 8'hff, digitalInputLines[7:0], 1'b1);
      end
      // dac pairing: low byte held until the high byte lands
      for (int i = 0; i < 3; i++) begin
         lo = 8'($random(seed));
         hi = 8'($random(seed));
         wr(at(OFS_DAC_LOW), lo);
         check("dacHold", 16'(expDac), 16'(dacValueBits));
         wr(at(OFS_DAC_HIGH), hi);
         expDac = {hi, lo[7:4]};
         check("dac", 16'(expDac), 16'(dacValueBits));
      end
      // range codes for all 16 channels, then read back by pointer
      for (int c = 0; c < 16; c++) begin
         wr(at(OFS_SCAN), {4'($random(seed)), 4'(c)});
         check("muxStart", 16'(c), 16'(muxChannel));
         wr(at(OFS_RESULT_HIGH), {4'h0, 4'(c) ^ 4'ha});
      end
      for (int c = 15; c >= 0; c--) begin
         wr(at(OFS_SCAN), {4'hf, 4'(c)});
         check("rangeCode", 16'(4'(c) ^ 4'ha), 16'(rangeCodeBits));
      end
      // window edges and unused offsets
      wr(BASE + 10'h023, ~expDout[7:0]);
      wr(BASE - 10'h001, 8'hff);
      wr(at(5'h07), 8'hff);
      wr(at(5'h1f), 8'hff);
      check("doutOutside", expDout, digitalOutputLines);
      check("dacOutside", 16'(expDac), 16'(dacValueBits));
      rdChk(BASE + 10'h020, 8'hff, 8'h00, 1'b0);
      rdChk(at(5'h1f), 8'hff, 8'h00, 1'b1);
      rdChk(at(OFS_DAC_LOW), 8'hff, 8'h00, 1'b1);
      rdChk(at(5'h07), 8'hff, 8'h00, 1'b1);
      // scan with soft triggers, buffer irq armed
      wr(at(OFS_CONV_CTRL), {6'h00, TRIG_SOFT});
      wr(at(OFS_BUF_IRQ_CTRL), 8'h01);
      wr(at(OFS_SCAN), 8'h73);
      expMux = 4'h3;
      check("muxStart", 16'h0003, 16'(muxChannel));
      for (int i = 0; i < 10; i++) begin
         convert(4'h3, 4'h7);
      end
      repeat (2) @(posedge sys_clk);
      #1;
      check("bufferIrq", 16'h0001, 16'(bufferIrq));
      wr(at(OFS_BUF_IRQ_CLR), 8'($random(seed)));
      @(posedge sys_clk);
      #1;
      check("bufferIrqClr", 16'h0000, 16'(bufferIrq));
      // drain in arrival order
      while (expSample.size() > 0) begin
         s = expSample.pop_front();
         rdChk(at(OFS_BUF_LOW), 8'hff, {s[7:4], s[3:0]}, 1'b1);
         rdChk(at(OFS_BUF_HIGH), 8'hff, s[15:8], 1'b1);
      end
      // conversion irq gate, status clear, external trigger edge
      wr(at(OFS_CONV_CTRL), {1'b1, 5'h00, TRIG_EXT});
      check("convIrq", 16'h0001, 16'(convIrq));
      wr(at(OFS_STATUS), 8'($random(seed)));
      check("convIrqClr", 16'h0000, 16'(convIrq));
      @(posedge sys_clk);
      extTrigger <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      check("extStart", 16'h0001, 16'(convStart));
      @(posedge sys_clk);
      extTrigger <= 1'b0;
      n = 0;
      while (convDone !== 1'b1 && n < 40) begin
         @(posedge sys_clk);
         #1;
         n = n + 1;
      end
      @(posedge sys_clk);
      #1;
      check("convIrqSet", 16'h0001, 16'(convIrq));
      // counter 0 on the external clock, reload of two
      wr(at(OFS_TIMER_CTRL), 8'h01);
      wr(at(OFS_CNT_MODE), 8'h00);
      wr(at(OFS_CNT0), 8'h02);
      wr(at(OFS_CNT0), 8'h00);
      rdChk(at(OFS_CNT0), 8'hff, 8'h02, 1'b1);
      c0 = counter0Out;
      repeat (2) begin
         @(posedge sys_clk);
         extCounterClk <= 1'b1;
         repeat (4) @(posedge sys_clk);
         extCounterClk <= 1'b0;
         repeat (3) @(posedge sys_clk);
      end
      repeat (4) @(posedge sys_clk);
      #1;
      check("counter0Out", 16'(!c0), 16'(counter0Out));
      // cascaded pacer, reload of two in both stages, fast then slow base
      wr(at(OFS_CNT1), 8'h02);
      wr(at(OFS_CNT1), 8'h00);
      wr(at(OFS_CNT2), 8'h02);
      wr(at(OFS_CNT2), 8'h00);
      wr(at(OFS_CONV_CTRL), {6'h00, TRIG_PACER});
      pacerPeriod(2 * 2 * FAST_DIV);
      n = 0;
      while (convStart !== 1'b1 && n < 100) begin
         @(posedge sys_clk);
         #1;
         n = n + 1;
      end
      check("pacerStart", 16'h0001, 16'(convStart));
      @(posedge sys_clk);
      baseClkSlow <= 1'b1;
      repeat (500) @(posedge sys_clk);
      pacerPeriod(2 * 2 * SLOW_DIV);
      stopTest();
   end
endmodule
